// File: verilog/dsp_pkg.sv
`default_nettype none
package dsp_pkg;
   // ***************************************************
   // bank geometry
   // ***************************************************
   localparam int NREG = 19;
   localparam int IW   = 5;
   localparam int DW   = 16;

   // storage index of each parameter
   localparam int IX_FSRC = 0;
   localparam int IX_RUN  = 1;
   localparam int IX_BASE = 2;
   localparam int IX_MAX  = 3;
   localparam int IX_AIN  = 4;
   localparam int IX_SFRQ = 5;
   localparam int IX_EFRQ = 6;
   localparam int IX_SPT  = 7;
   localparam int IX_EPT  = 8;
   localparam int IX_SFM  = 9;
   localparam int IX_FILT = 10;
   localparam int IX_PS0  = 11;
   localparam int IX_PS1  = 12;
   localparam int IX_PS2  = 13;
   localparam int IX_PS3  = 14;
   localparam int IX_PS4  = 15;
   localparam int IX_BAS2 = 16;
   localparam int IX_MAX2 = 17;
   localparam int IX_PS02 = 18;

   // network register number of each index
   localparam logic [DW-1:0] REG_ADDR [NREG] = '{
      16'h1019, 16'h101A, 16'h101B, 16'h101C, 16'h101D, 16'h1020, 16'h1022,
      16'h1023, 16'h1024, 16'h1025, 16'h1026, 16'h1029, 16'h102B, 16'h102D,
      16'h102F, 16'h1031, 16'h150C, 16'h150D, 16'h150F};

   // value after reset of each index, all inside its legal range
   localparam logic [DW-1:0] RST_VAL [NREG] = '{
      16'h0000, 16'h0001, 16'h003C, 16'h003C, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0064, 16'h0001, 16'h0008, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h003C, 16'h003C, 16'h0000};

   // ***************************************************
   // codes and limits
   // ***************************************************
   localparam logic [DW-1:0] FSRC_NET   = 16'h0003;
   localparam logic [DW-1:0] FSRC_CALC  = 16'h000A;
   localparam logic [DW-1:0] RUN_TERM   = 16'h0001;
   localparam logic [DW-1:0] RUN_NET    = 16'h0003;
   localparam logic [DW-1:0] AIN_MAXC   = 16'h0003;
   localparam logic [DW-1:0] SFM_MAXC   = 16'h0001;
   localparam logic [DW-1:0] HZ_MIN     = 16'h001E;
   localparam logic [DW-1:0] HZ_MAX     = 16'h0190;
   localparam logic [DW-1:0] DHZ_MAX    = 16'h0FA0;
   localparam logic [DW-1:0] PCT_MAX    = 16'h0064;
   localparam logic [DW-1:0] FILT_MIN   = 16'h0001;
   localparam logic [DW-1:0] FILT_ALIAS = 16'h0011;
   localparam logic [4:0]    FILT_DEEP  = 5'h10;
endpackage
`default_nettype wire

// File: verilog/dsp_param_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - every parameter is a read/write holding register
// - frequency source codes 0-3 and 10
// - run source codes 1 to 3
// - motor1 base 30 Hz to motor1 max
// - motor2 base 30 Hz to motor2 max
// - motor1 max from base to 400 Hz
// - motor2 max from base to 400 Hz
// - analog select codes 0 and 1
// - analog select codes 2 and 3
// - range start frequency 0 to 4000
// - range end frequency 0 to 4000
// - range start point 0 to 100
// - range end point 0 to 100
// - start frequency mode codes 0 and 1
// - filter 1 to 16, 17 means 16
// - motor1 speed 0: zero or start..4000
// - motor2 speed 0: zero or start..4000
// - speeds 1-4: zero or start..4000
module dsp_param_regs (
   // clock and reset
   input  wire logic                      clock_i,
   input  wire logic                      rstn_i,
   // holding register access
   input  wire logic                      req_i,
   input  wire logic                      we_i,
   input  wire logic [dsp_pkg::DW-1:0]    addr_i,
   input  wire logic [dsp_pkg::DW-1:0]    wdata_i,
   output logic      [dsp_pkg::DW-1:0]    rdata_o,
   output logic                           ack_o,
   output logic                           err_o,
   // start frequency from the drive core, 0.1 Hz
   input  wire logic [dsp_pkg::DW-1:0]    start_freq_i,
   // parameter values toward the drive core
   output logic      [dsp_pkg::DW-1:0]    freq_reference_source_o,
   output logic      [dsp_pkg::DW-1:0]    run_command_source_o,
   output logic      [dsp_pkg::DW-1:0]    base_frequency_o,
   output logic      [dsp_pkg::DW-1:0]    maximum_frequency_o,
   output logic      [dsp_pkg::DW-1:0]    analog_input_select_o,
   output logic      [dsp_pkg::DW-1:0]    analog_range_start_freq_o,
   output logic      [dsp_pkg::DW-1:0]    analog_range_end_freq_o,
   output logic      [dsp_pkg::DW-1:0]    analog_range_start_point_o,
   output logic      [dsp_pkg::DW-1:0]    analog_range_end_point_o,
   output logic      [dsp_pkg::DW-1:0]    start_freq_mode_o,
   output logic      [dsp_pkg::DW-1:0]    input_filter_samples_o,
   output logic      [dsp_pkg::DW-1:0]    preset_speed_0_o,
   output logic      [dsp_pkg::DW-1:0]    preset_speed_1_o,
   output logic      [dsp_pkg::DW-1:0]    preset_speed_2_o,
   output logic      [dsp_pkg::DW-1:0]    preset_speed_3_o,
   output logic      [dsp_pkg::DW-1:0]    preset_speed_4_o,
   output logic      [dsp_pkg::DW-1:0]    base_frequency_motor2_o,
   output logic      [dsp_pkg::DW-1:0]    maximum_frequency_motor2_o,
   output logic      [dsp_pkg::DW-1:0]    preset_speed_0_motor2_o,
   // effective averaging depth, 1 to 16
   output logic      [4:0]                filter_depth_o
);
   import dsp_pkg::*;

   // ***************************************************
   // storage and decode
   // ***************************************************
   logic [DW-1:0] regs_reg [NREG];
   logic [DW-1:0] rdata_reg;
   logic [DW-1:0] rdata_next;
   logic          ack_reg;
   logic          err_reg;
   logic [4:0]    depth_reg;
   logic [4:0]    depth_next;
   logic [NREG-1:0] hit;
   logic [NREG-1:0] val_ok;
   logic [NREG-1:0] wr_en;
   logic [IW-1:0] hit_idx;
   logic          hit_any;
   logic          wr_req;
   logic          rd_req;
   logic          accept;
   logic          ps_ok;
   logic          ps_legal;
   logic [DW-1:0] wd;

   // one comparator per register number
   genvar g;
   generate
      for (g = 0; g < NREG; g++) begin : g_hit
         assign hit[g] = (addr_i == REG_ADDR[g]);
      end
   endgenerate

   // addresses are unique, so at most one hit bit is set
   always_comb begin
      hit_idx = '0;
      for (int k = 0; k < NREG; k++) begin
         if (hit[k]) begin
            hit_idx = IW'(k);
         end
      end
   end

   assign hit_any = |hit;
   assign wr_req  = req_i & we_i;
   assign rd_req  = req_i & ~we_i;
   assign wd      = wdata_i;

   // ***************************************************
   // range checks per register
   // ***************************************************
   // preset speeds: zero, or start frequency up to the top
   // start_freq_i is looked at on the write cycle only; a later rise of
   // the start frequency does not re-check presets already stored
   assign ps_ok    = (wd == '0) || ((wd >= start_freq_i) && (wd <= DHZ_MAX));
   assign ps_legal = ps_ok;

   assign val_ok[IX_FSRC] = (wd <= FSRC_NET) || (wd == FSRC_CALC);
   assign val_ok[IX_RUN]  = (wd >= RUN_TERM) && (wd <= RUN_NET);
   assign val_ok[IX_BASE] = (wd >= HZ_MIN) && (wd <= regs_reg[IX_MAX]);
   // max bounded below by base so the pair never crosses
   assign val_ok[IX_MAX]  = (wd >= HZ_MIN) && (wd <= HZ_MAX) && (wd >= regs_reg[IX_BASE]);
   assign val_ok[IX_AIN]  = (wd <= AIN_MAXC);
   assign val_ok[IX_SFRQ] = (wd <= DHZ_MAX);
   assign val_ok[IX_EFRQ] = (wd <= DHZ_MAX);
   assign val_ok[IX_SPT]  = (wd <= PCT_MAX);
   assign val_ok[IX_EPT]  = (wd <= PCT_MAX);
   assign val_ok[IX_SFM]  = (wd <= SFM_MAXC);
   assign val_ok[IX_FILT] = (wd >= FILT_MIN) && (wd <= FILT_ALIAS);
   assign val_ok[IX_PS0]  = ps_legal;
   assign val_ok[IX_PS1]  = ps_legal;
   assign val_ok[IX_PS2]  = ps_legal;
   assign val_ok[IX_PS3]  = ps_legal;
   assign val_ok[IX_PS4]  = ps_legal;
   assign val_ok[IX_BAS2] = (wd >= HZ_MIN) && (wd <= regs_reg[IX_MAX2]);
   assign val_ok[IX_MAX2] = (wd >= HZ_MIN) && (wd <= HZ_MAX) && (wd >= regs_reg[IX_BAS2]);
   assign val_ok[IX_PS02] = ps_legal;

   // cross checks read the partner value as stored now, so base and max
   // written in either order never leave base above max
   // a write lands only on a mapped register with a legal value
   assign accept = wr_req & hit_any & val_ok[hit_idx];

   // ***************************************************
   // register storage
   // ***************************************************
   generate
      for (g = 0; g < NREG; g++) begin : g_store
         assign wr_en[g] = accept & hit[g];

         // rejected writes never reach the flops
         always_ff @(posedge clock_i or negedge rstn_i) begin
            if (!rstn_i) begin
               regs_reg[g] <= RST_VAL[g];
            end else if (wr_en[g]) begin
               regs_reg[g] <= wd;
            end
         end
      end
   endgenerate

   // ***************************************************
   // answer path
   // ***************************************************
   // reads of unmapped numbers return zero beside the error pulse
   // zero on writes too, so a stale read value never looks like an answer
   assign rdata_next = (rd_req && hit_any) ? regs_reg[hit_idx] : '0;

   // 17 aliases to the deepest average
   // registered, so the filter sees no path back to the bus decode
   assign depth_next = (regs_reg[IX_FILT] == FILT_ALIAS) ? FILT_DEEP :
                       regs_reg[IX_FILT][4:0];

   // answer one cycle after the request, ack xor err
   // no back-pressure: every taken request is answered on the next edge
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ack_reg   <= 1'b0;
         err_reg   <= 1'b0;
         rdata_reg <= '0;
         depth_reg <= FILT_DEEP;
      end else begin
         ack_reg   <= (rd_req & hit_any) | accept;
         err_reg   <= req_i & ~((rd_req & hit_any) | accept);
         rdata_reg <= rdata_next;
         depth_reg <= depth_next;
      end
   end

   // ***************************************************
   // outputs
   // ***************************************************
   // every output reads a flop directly, no logic in between
   assign rdata_o                    = rdata_reg;
   assign ack_o                      = ack_reg;
   assign err_o                      = err_reg;
   assign filter_depth_o             = depth_reg;
   assign freq_reference_source_o    = regs_reg[IX_FSRC];
   assign run_command_source_o       = regs_reg[IX_RUN];
   assign base_frequency_o           = regs_reg[IX_BASE];
   assign maximum_frequency_o        = regs_reg[IX_MAX];
   assign analog_input_select_o      = regs_reg[IX_AIN];
   assign analog_range_start_freq_o  = regs_reg[IX_SFRQ];
   assign analog_range_end_freq_o    = regs_reg[IX_EFRQ];
   assign analog_range_start_point_o = regs_reg[IX_SPT];
   assign analog_range_end_point_o   = regs_reg[IX_EPT];
   assign start_freq_mode_o          = regs_reg[IX_SFM];
   assign input_filter_samples_o     = regs_reg[IX_FILT];
   assign preset_speed_0_o           = regs_reg[IX_PS0];
   assign preset_speed_1_o           = regs_reg[IX_PS1];
   assign preset_speed_2_o           = regs_reg[IX_PS2];
   assign preset_speed_3_o           = regs_reg[IX_PS3];
   assign preset_speed_4_o           = regs_reg[IX_PS4];
   assign base_frequency_motor2_o    = regs_reg[IX_BAS2];
   assign maximum_frequency_motor2_o = regs_reg[IX_MAX2];
   assign preset_speed_0_motor2_o    = regs_reg[IX_PS02];

   // ***************************************************
   // assertions
   // ***************************************************
   // reset gates every property; the whole bank resets to legal values
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rstn_i);

   sequence s_good_write;
      wr_req && hit_any && val_ok[hit_idx];
   endsequence

   sequence s_bad_write;
      wr_req && hit_any && !val_ok[hit_idx];
   endsequence

   write_lands_a : assert property (s_good_write |=> ack_o && !err_o &&
      (regs_reg[$past(hit_idx)] == $past(wdata_i)))
      else $error("accepted write not stored");

   bad_write_kept_a : assert property (s_bad_write |=> err_o && !ack_o &&
      regs_reg[$past(hit_idx)] == $past(regs_reg[hit_idx]))
      else $error("rejected write changed a register");

   unmapped_err_a : assert property (req_i && !hit_any |=> err_o && rdata_o == '0)
      else $error("unmapped access not refused");

   read_back_a : assert property (rd_req && hit_any |=> ack_o &&
      rdata_o == $past(regs_reg[hit_idx]))
      else $error("read returned wrong data");

   answer_once_a : assert property (!req_i |=> !ack_o && !err_o)
      else $error("answer without a request");

   base_max_a : assert property (regs_reg[IX_BASE] >= HZ_MIN &&
      regs_reg[IX_BASE] <= regs_reg[IX_MAX] && regs_reg[IX_MAX] <= HZ_MAX)
      else $error("motor1 base or max out of range");

   base_max2_a : assert property (regs_reg[IX_BAS2] >= HZ_MIN &&
      regs_reg[IX_BAS2] <= regs_reg[IX_MAX2] && regs_reg[IX_MAX2] <= HZ_MAX)
      else $error("motor2 base or max out of range");

   fsrc_code_a : assert property (regs_reg[IX_FSRC] <= FSRC_NET ||
      regs_reg[IX_FSRC] == FSRC_CALC)
      else $error("frequency source code illegal");

   run_code_a : assert property (regs_reg[IX_RUN] >= RUN_TERM &&
      regs_reg[IX_RUN] <= RUN_NET)
      else $error("run source code illegal");

   filt_alias_a : assert property ((regs_reg[IX_FILT] == FILT_ALIAS) [*2] |->
      filter_depth_o == FILT_DEEP)
      else $error("filter 17 not mapped to 16");

   preset_top_a : assert property (regs_reg[IX_PS0] <= DHZ_MAX &&
      regs_reg[IX_PS02] <= DHZ_MAX)
      else $error("preset speed above top");

   range_pts_a : assert property (regs_reg[IX_SPT] <= PCT_MAX &&
      regs_reg[IX_EPT] <= PCT_MAX)
      else $error("range point above 100");

   // ***************************************************
   // further guards on answers, codes and range tops
   // ***************************************************
   sequence s_answer;
      ack_o != err_o;
   endsequence

   // exactly one of ack and err follows each taken request
   answer_pair_a : assert property (req_i |=> s_answer)
      else $error("request without a single answer");

   answer_excl_a : assert property (!(ack_o && err_o))
      else $error("ack and err together");

   // writes hand back no data, so a stale read value never leaks
   write_no_data_a : assert property (wr_req |=> rdata_o == '0)
      else $error("write returned read data");

   fsrc_calc_a : assert property (wr_req && hit[IX_FSRC] && wdata_i == FSRC_CALC |=>
      freq_reference_source_o == FSRC_CALC)
      else $error("calculate code not stored");

   run_zero_a : assert property (wr_req && hit[IX_RUN] && wdata_i < RUN_TERM |=>
      err_o && $stable(regs_reg[IX_RUN]))
      else $error("run source zero accepted");

   ain_code_a : assert property (regs_reg[IX_AIN] <= AIN_MAXC)
      else $error("analog select code illegal");

   ain_refuse_a : assert property (wr_req && hit[IX_AIN] && wdata_i > AIN_MAXC |=>
      err_o && $stable(regs_reg[IX_AIN]))
      else $error("analog select code above 3 accepted");

   sfreq_top_a : assert property (regs_reg[IX_SFRQ] <= DHZ_MAX)
      else $error("range start frequency above top");

   efreq_top_a : assert property (regs_reg[IX_EFRQ] <= DHZ_MAX)
      else $error("range end frequency above top");

   sfm_code_a : assert property (regs_reg[IX_SFM] <= SFM_MAXC)
      else $error("start frequency mode code illegal");

   sfm_store_a : assert property (wr_req && hit[IX_SFM] && wdata_i <= SFM_MAXC |=>
      start_freq_mode_o == $past(wdata_i))
      else $error("start frequency mode not stored");

   // the depth output trails the filter register by one edge
   filt_range_a : assert property (regs_reg[IX_FILT] >= FILT_MIN &&
      regs_reg[IX_FILT] <= FILT_ALIAS)
      else $error("filter depth register out of range");

   depth_follow_a : assert property (regs_reg[IX_FILT] != FILT_ALIAS |=>
      {11'h000, filter_depth_o} == $past(regs_reg[IX_FILT]))
      else $error("filter depth output does not follow");

   // presets below the start frequency are refused unless zero
   preset_rest_a : assert property (regs_reg[IX_PS1] <= DHZ_MAX &&
      regs_reg[IX_PS2] <= DHZ_MAX && regs_reg[IX_PS3] <= DHZ_MAX &&
      regs_reg[IX_PS4] <= DHZ_MAX)
      else $error("preset speed 1 to 4 above top");

   preset_floor_a : assert property (wr_req && hit[IX_PS1] && wdata_i != '0 &&
      wdata_i < start_freq_i |=> err_o && $stable(regs_reg[IX_PS1]))
      else $error("preset below start frequency accepted");

endmodule
`default_nettype wire

// File: verif/dsp_master.sv
`timescale 1ns/1ps
`default_nettype none
// ******************************
// network master model
// ******************************
module dsp_master (
   // clock
   input  wire logic                   clock_i,
   // request toward the bank
   output logic                        req_o,
   output logic                        we_o,
   output logic [dsp_pkg::DW-1:0]      addr_o,
   output logic [dsp_pkg::DW-1:0]      wdata_o,
   // answer from the bank
   input  wire logic                   ack_i,
   input  wire logic                   err_i,
   input  wire logic [dsp_pkg::DW-1:0] rdata_i
);
   import dsp_pkg::*;

   // idle at time zero, no request pending
   initial begin
      req_o   = 1'b0;
      we_o    = 1'b0;
      addr_o  = 16'h0000;
      wdata_o = 16'h0000;
   end

   // one access: request for one edge, answer sampled one cycle later
   // released fields are inverted so stale values never look valid
   task automatic access(input logic w, input logic [DW-1:0] a, input logic [DW-1:0] d,
                         output logic k, output logic e, output logic [DW-1:0] q);
      @(negedge clock_i);
      req_o   = 1'b1;
      we_o    = w;
      addr_o  = a;
      wdata_o = d;
      @(negedge clock_i);
      k       = ack_i;
      e       = err_i;
      q       = rdata_i;
      req_o   = 1'b0;
      we_o    = ~w;
      addr_o  = ~a;
      wdata_o = ~d;
   endtask
endmodule
`default_nettype wire

// File: verif/dsp_param_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dsp_param_regs_tb;
   import dsp_pkg::*;
   // ******************************
   // clock, reset and wiring
   // ******************************
   logic          clock_i;
   logic          rstn_i;
   logic          req, we, ack, err;
   logic [DW-1:0] addr, wdata, rdata, start_freq;
   wire logic [DW-1:0] par [NREG];
   logic [4:0]    depth;
   logic [DW-1:0] exp_v [NREG];
   int            n_mismatch;
   int            num_checks;
   localparam int PS_IX [6] = '{IX_PS0, IX_PS1, IX_PS2, IX_PS3, IX_PS4, IX_PS02};

   initial begin
      clock_i = 1'b0;
      forever #20 clock_i = ~clock_i;
   end

   dsp_master mst_u (.clock_i(clock_i), .req_o(req), .we_o(we), .addr_o(addr),
      .wdata_o(wdata), .ack_i(ack), .err_i(err), .rdata_i(rdata));

   dsp_param_regs dut_u (.clock_i(clock_i), .rstn_i(rstn_i), .req_i(req), .we_i(we),
      .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata), .ack_o(ack), .err_o(err),
      .start_freq_i(start_freq), .freq_reference_source_o(par[IX_FSRC]),
      .run_command_source_o(par[IX_RUN]), .base_frequency_o(par[IX_BASE]),
      .maximum_frequency_o(par[IX_MAX]), .analog_input_select_o(par[IX_AIN]),
      .analog_range_start_freq_o(par[IX_SFRQ]), .analog_range_end_freq_o(par[IX_EFRQ]),
      .analog_range_start_point_o(par[IX_SPT]), .analog_range_end_point_o(par[IX_EPT]),
      .start_freq_mode_o(par[IX_SFM]), .input_filter_samples_o(par[IX_FILT]),
      .preset_speed_0_o(par[IX_PS0]), .preset_speed_1_o(par[IX_PS1]),
      .preset_speed_2_o(par[IX_PS2]), .preset_speed_3_o(par[IX_PS3]),
      .preset_speed_4_o(par[IX_PS4]), .base_frequency_motor2_o(par[IX_BAS2]),
      .maximum_frequency_motor2_o(par[IX_MAX2]), .preset_speed_0_motor2_o(par[IX_PS02]),
      .filter_depth_o(depth));

   // ******************************
   // compare and access tasks
   // ******************************
   task automatic chk_val(input logic [DW-1:0] g, input logic [DW-1:0] x);
      num_checks++;
      if (g !== x) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask

   task automatic chk_bit(input logic g, input logic x);
      chk_val({15'h0000, g}, {15'h0000, x});
   endtask

   // write, expect stored or refused, then read back and look at the output
   task automatic try(input int ix, input logic [DW-1:0] v, input logic ok);
      logic          k, e;
      logic [DW-1:0] q;
      mst_u.access(1'b1, REG_ADDR[ix], v, k, e, q);
      chk_bit(k, ok);
      chk_bit(e, ~ok);
      if (ok) exp_v[ix] = v;
      mst_u.access(1'b0, REG_ADDR[ix], 16'h0000, k, e, q);
      chk_bit(k, 1'b1);
      chk_val(q, exp_v[ix]);
      chk_val(par[ix], exp_v[ix]);
   endtask

   // every register read against the model, plus one unmapped number
   task automatic chk_all();
      logic          k, e;
      logic [DW-1:0] q;
      for (int i = 0; i < NREG; i++) begin
         mst_u.access(1'b0, REG_ADDR[i], 16'h0000, k, e, q);
         chk_val(q, exp_v[i]);
         chk_val(par[i], exp_v[i]);
      end
      mst_u.access(1'b0, 16'h1021, 16'h0000, k, e, q);
      chk_bit(k, 1'b0);
      chk_bit(e, 1'b1);
      chk_val(q, 16'h0000);
      mst_u.access(1'b1, 16'h1021, 16'h0005, k, e, q);
      chk_bit(k, 1'b0);
      chk_bit(e, 1'b1);
   endtask

   task automatic close_out();
      $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // ******************************
   // main sequence
   // ******************************
   initial begin
      int bi, mi, lim;
      n_mismatch = 0;
      num_checks = 0;
      rstn_i     = 1'b0;
      start_freq = 16'h0032;
      exp_v      = RST_VAL;
      repeat (8) @(negedge clock_i);
      chk_val({11'h000, depth}, 16'h0010);
      rstn_i = 1'b1;
      chk_all();
      chk_val({11'h000, depth}, 16'h0008);
      // code sets, legal and illegal neighbours
      try(IX_FSRC, 16'h000A, 1'b1);
      try(IX_FSRC, 16'h0004, 1'b0);
      try(IX_FSRC, 16'h0003, 1'b1);
      try(IX_FSRC, 16'h000B, 1'b0);
      try(IX_FSRC, 16'h0000, 1'b1);
      try(IX_RUN, 16'h0000, 1'b0);
      try(IX_RUN, 16'h0002, 1'b1);
      try(IX_RUN, 16'h0004, 1'b0);
      try(IX_RUN, 16'h0003, 1'b1);
      try(IX_AIN, 16'h0003, 1'b1);
      try(IX_AIN, 16'h0004, 1'b0);
      try(IX_AIN, 16'h0001, 1'b1);
      try(IX_AIN, 16'h0002, 1'b1);
      try(IX_AIN, 16'h0000, 1'b1);
      try(IX_SFM, 16'h0000, 1'b1);
      try(IX_SFM, 16'h0002, 1'b0);
      try(IX_SFM, 16'h0001, 1'b1);
      // base and maximum cross limits, both motors
      for (int m = 0; m < 2; m++) begin
         bi = (m == 0) ? IX_BASE : IX_BAS2;
         mi = (m == 0) ? IX_MAX : IX_MAX2;
         try(bi, 16'h001D, 1'b0);
         try(bi, 16'h003D, 1'b0);
         try(mi, 16'h0191, 1'b0);
         try(mi, 16'h0190, 1'b1);
         try(bi, 16'h0190, 1'b1);
         try(mi, 16'h018F, 1'b0);
         try(bi, 16'h001E, 1'b1);
         try(mi, 16'h001E, 1'b1);
      end
      // analog range limits
      for (int i = IX_SFRQ; i <= IX_EPT; i++) begin
         lim = (i < IX_SPT) ? 16'h0FA0 : 16'h0064;
         try(i, lim[DW-1:0], 1'b1);
         try(i, lim[DW-1:0] + 16'h0001, 1'b0);
      end
      // filter depth, 17 aliases to 16
      try(IX_FILT, 16'h0000, 1'b0);
      try(IX_FILT, 16'h0011, 1'b1);
      chk_val({11'h000, depth}, 16'h0010);
      try(IX_FILT, 16'h0012, 1'b0);
      try(IX_FILT, 16'h0001, 1'b1);
      chk_val({11'h000, depth}, 16'h0001);
      // presets: zero or start frequency up to 400.0 Hz
      foreach (PS_IX[j]) begin
         try(PS_IX[j], 16'h0FA0, 1'b1);
         try(PS_IX[j], 16'h0031, 1'b0);
         try(PS_IX[j], 16'h0032, 1'b1);
         try(PS_IX[j], 16'h0FA1, 1'b0);
         try(PS_IX[j], 16'h0000, 1'b1);
      end
      // a higher start frequency moves the preset floor with it
      start_freq = 16'h0064;
      try(IX_PS1, 16'h0063, 1'b0);
      try(IX_PS1, 16'h0064, 1'b1);
      // reset in mid-run brings every register back
      chk_all();
      @(negedge clock_i);
      rstn_i = 1'b0;
      repeat (8) @(negedge clock_i);
      chk_val({11'h000, depth}, 16'h0010);
      rstn_i = 1'b1;
      exp_v  = RST_VAL;
      chk_all();
      chk_val({11'h000, depth}, 16'h0008);
      close_out();
   end

   // watchdog, well beyond the expected run
   initial begin
      repeat (20000) @(posedge clock_i);
      n_mismatch++;
      close_out();
   end
endmodule
`default_nettype wire
